// File: pdc_pkg.sv
`default_nettype none
package pdc_pkg;
  // ****************************************************
  // serial word layout
  // ****************************************************
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_IF_R = 2'h0;
  localparam logic [1:0] SEL_IF_N = 2'h1;
  localparam logic [1:0] SEL_RF_R = 2'h2;
  localparam logic [1:0] SEL_RF_N = 2'h3;
  localparam int FRAC_LSB    = 2;
  localparam int FRAC_W      = 4;
  localparam int SWAL_LSB    = 6;
  localparam int SWAL_W      = 5;
  localparam int PROG_LSB    = 11;
  localparam int PROG_W      = 10;
  localparam int GP_OUTPUT_PIN0_BIT    = 17;
  localparam int GP_OUTPUT_PIN1_BIT    = 18;
  localparam int TEST_BIT    = 19;
  localparam int ACQ_BIT     = 20;
  localparam int PDMODE_BIT  = 21;
  localparam int PRESC_BIT   = 21;
  localparam int CP8X_BIT    = 21;
  localparam int IFGAIN8_BIT = 21;
  localparam int PWDN_BIT    = 22;
  localparam int CNTRST_BIT  = 23;
  localparam logic [23:0] WORD_RST = 24'h00_0000;
  // ****************************************************
  // divide ratios
  // ****************************************************
  localparam logic [5:0] P_BIG_LO   = 6'h10;
  localparam logic [5:0] P_BIG_HI   = 6'h20;
  localparam logic [5:0] P_SMALL_LO = 6'h08;
  localparam logic [5:0] P_SMALL_HI = 6'h10;
  localparam logic [5:0] P_IF       = 6'h08;
  localparam logic [4:0] MOD_15     = 5'h0f;
  localparam logic [4:0] MOD_16     = 5'h10;
  localparam logic [4:0] SWAL_MAX_SMALL = 5'h0f;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_NS      = 8;
  localparam int NARROW_NS   = 15;
  localparam int WIDE_NS     = 30;
  localparam int NARROW_CYC  = (NARROW_NS / CLK_NS < 1) ? 1
                               : NARROW_NS / CLK_NS;
  localparam int WIDE_CYC    = (WIDE_NS / CLK_NS < 1) ? 1
                               : WIDE_NS / CLK_NS;
  localparam int LOCK_CYCLES = 5;
  localparam int LINK_NS     = 125;
  localparam int LINK_HALF_CYC = (LINK_NS / (2 * CLK_NS) < 1) ? 1
                                 : LINK_NS / (2 * CLK_NS);
  // ****************************************************
  // host registers
  // ****************************************************
  localparam logic [7:0] REG_WORD   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int ST_BUSY    = 0;
  localparam int ST_DROPPED = 1;
  typedef enum logic [3:0] {
    PDC_IDLE   = 4'h1,
    PDC_CLK_LO = 4'h2,
    PDC_CLK_HI = 4'h4,
    PDC_LATCH  = 4'h8
  } pdc_host_state_t;
endpackage
`default_nettype wire

// File: pdc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pdc_link_if;
  logic sdata;
  logic le;
  logic sclk;
  modport host (output sdata, output le, output sclk);
  modport dev  (input sdata, input le, input sclk);
endinterface
`default_nettype wire

// File: pdc_device.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_device import pdc_pkg::*; #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  pdc_link_if.dev          link,
  input  wire logic        frac_mod16,
  input  wire logic        analog_ld_select,
  input  wire logic        ref_tick,
  input  wire logic        phase_err,
  input  wire logic        rf_cp_pulse_done,
  input  wire logic        if_cp_pulse_done,
  output logic [4:0]       rf_swallow_count,
  output logic [9:0]       rf_program_count,
  output logic [3:0]       fraction_numerator,
  output logic [4:0]       fraction_modulus,
  output logic             frac_code_invalid,
  output logic             swallow_out_of_range,
  output logic             prescaler_ratio_select,
  output logic [5:0]       prescaler_modulus,
  output logic [15:0]      rf_n_value,
  output logic             rf_counter_reset,
  output logic             if_counter_reset,
  output logic             rf_loop_powerdown,
  output logic             if_loop_powerdown,
  output logic             gp_output_pin0,
  output logic             gp_output_pin0_oe_b,
  output logic             gp_output_pin1,
  output logic             gp_output_pin1_oe_b,
  output logic             lock_detect,
  output logic             multifunction_lock_out,
  output logic             multifunction_lock_out_oe_b
);
  // ****************************************************
  // pin synchronisers
  // ****************************************************
  // bit 2 clock, bit 1 latch enable, bit 0 data
  logic [2:0] pin_raw;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_filt;
  logic [2:0] pin_rise;
  assign pin_raw = {link.sclk, link.le, link.sdata};
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  // a change counts only once two stages agree
  for (genvar g = 0; g < 3; g++) begin : g_filt
    assign pin_rise[g] = (sync2[g] == sync3[g]) && sync3[g] && !pin_filt[g];
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        pin_filt[g] <= 1'b0;
      end else if (sync2[g] == sync3[g]) begin
        pin_filt[g] <= sync3[g];
      end
    end
  end
  // ****************************************************
  // shift register and word latches
  // ****************************************************
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] rf_divider_word;
  logic [WORD_W-1:0] if_divider_word;
  logic [WORD_W-1:0] rf_ref_word;
  logic [WORD_W-1:0] if_ref_word;
  // never gated by power-down
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shift_reg <= WORD_RST;
    end else if (pin_rise[2]) begin
      shift_reg <= {shift_reg[WORD_W-2:0], pin_filt[0]};
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rf_divider_word <= WORD_RST;
      if_divider_word <= WORD_RST;
      rf_ref_word     <= WORD_RST;
      if_ref_word     <= WORD_RST;
    end else if (pin_rise[1]) begin
      case (shift_reg[1:0])
        SEL_RF_N: rf_divider_word <= shift_reg;
        SEL_IF_N: if_divider_word <= shift_reg;
        SEL_RF_R: rf_ref_word     <= shift_reg;
        SEL_IF_R: if_ref_word     <= shift_reg;
        default:  rf_divider_word <= rf_divider_word;
      endcase
    end
  end
  logic [4:0]  word_a;
  logic [9:0]  word_b;
  logic [5:0]  next_p;
  logic [15:0] next_n;
  assign word_a = rf_divider_word[SWAL_LSB +: SWAL_W];
  assign word_b = rf_divider_word[PROG_LSB +: PROG_W];
  always_comb begin
    if (LARGE_VARIANT) begin
      next_p = rf_divider_word[PRESC_BIT] ? P_BIG_HI : P_BIG_LO;
    end else begin
      next_p = rf_divider_word[PRESC_BIT] ? P_SMALL_HI : P_SMALL_LO;
    end
    next_n = ({6'h00, word_b} * {10'h000, next_p}) + {11'h000, word_a};
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rf_swallow_count       <= 5'h00;
      rf_program_count       <= 10'h000;
      fraction_numerator     <= 4'h0;
      fraction_modulus       <= MOD_15;
      frac_code_invalid      <= 1'b0;
      swallow_out_of_range   <= 1'b0;
      prescaler_ratio_select <= 1'b0;
      prescaler_modulus      <= P_SMALL_LO;
      rf_n_value             <= 16'h0000;
      rf_counter_reset       <= 1'b0;
      if_counter_reset       <= 1'b0;
    end else begin
      rf_swallow_count       <= word_a;
      rf_program_count       <= word_b;
      fraction_numerator     <= rf_divider_word[FRAC_LSB +: FRAC_W];
      fraction_modulus       <= frac_mod16 ? MOD_16 : MOD_15;
      // all-ones numerator has no meaning over 15
      frac_code_invalid      <= !frac_mod16
                                && (&rf_divider_word[FRAC_LSB +: FRAC_W]);
      swallow_out_of_range   <= !LARGE_VARIANT
                                && (word_a > SWAL_MAX_SMALL);
      prescaler_ratio_select <= rf_divider_word[PRESC_BIT];
      prescaler_modulus      <= next_p;
      rf_n_value             <= next_n;
      rf_counter_reset       <= rf_divider_word[CNTRST_BIT];
      if_counter_reset       <= if_divider_word[CNTRST_BIT];
    end
  end
  // ****************************************************
  // power-down
  // ****************************************************
  logic [1:0] pd_req;
  logic [1:0] pd_act;
  logic [1:0] pump_done;
  logic       pd_sync_mode;
  assign pd_req       = {if_divider_word[PWDN_BIT], rf_divider_word[PWDN_BIT]};
  assign pump_done    = {if_cp_pulse_done, rf_cp_pulse_done};
  assign pd_sync_mode = if_divider_word[PDMODE_BIT];
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pd_act <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!pd_req[i]) begin
          pd_act[i] <= 1'b0;
        end else if (!pd_sync_mode) begin
          pd_act[i] <= 1'b1;
        end else if (pump_done[i]) begin
          pd_act[i] <= 1'b1;
        end
      end
    end
  end
  // counters stop and pump goes high impedance while set
  assign rf_loop_powerdown = pd_act[0];
  assign if_loop_powerdown = pd_act[1];
  // ****************************************************
  // general purpose pins
  // ****************************************************
  logic acq_mode;
  assign acq_mode = if_divider_word[ACQ_BIT];
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gp_output_pin0      <= 1'b0;
      gp_output_pin0_oe_b <= 1'b0;
      gp_output_pin1      <= 1'b0;
      gp_output_pin1_oe_b <= 1'b0;
    end else if (acq_mode) begin
      // level bits are don't care here
      gp_output_pin0      <= 1'b0;
      gp_output_pin0_oe_b <= !rf_ref_word[CP8X_BIT];
      gp_output_pin1      <= 1'b0;
      gp_output_pin1_oe_b <= !if_ref_word[IFGAIN8_BIT];
    end else begin
      gp_output_pin0      <= if_divider_word[GP_OUTPUT_PIN0_BIT];
      gp_output_pin0_oe_b <= 1'b0;
      gp_output_pin1      <= if_divider_word[GP_OUTPUT_PIN1_BIT];
      gp_output_pin1_oe_b <= 1'b0;
    end
  end
  // ****************************************************
  // lock filter
  // ****************************************************
  logic [3:0] err_len;
  logic [2:0] good_cnt;
  logic       err_narrow;
  logic       err_wide;
  assign err_narrow = err_len > 4'(NARROW_CYC);
  assign err_wide   = err_len > 4'(WIDE_CYC);
  // error width in clocks over one reference cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      err_len <= 4'h0;
    end else if (ref_tick) begin
      err_len <= {3'h0, phase_err};
    end else if (phase_err && (err_len != 4'hf)) begin
      err_len <= err_len + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b || pd_act[0]) begin
      lock_detect <= 1'b0;
      good_cnt    <= 3'h0;
    end else if (ref_tick) begin
      if (lock_detect) begin
        if (err_wide) begin
          lock_detect <= 1'b0;
          good_cnt    <= 3'h0;
        end
      end else if (err_narrow) begin
        good_cnt <= 3'h0;
      end else if (good_cnt == 3'(LOCK_CYCLES - 1)) begin
        lock_detect <= 1'b1;
        good_cnt    <= 3'h0;
      end else begin
        good_cnt <= good_cnt + 3'h1;
      end
    end
  end
  // analog mode: open drain, pulled low while phases agree and the RF loop is not powered down
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      multifunction_lock_out      <= 1'b0;
      multifunction_lock_out_oe_b <= 1'b0;
    end else if (analog_ld_select) begin
      multifunction_lock_out      <= 1'b0;
      multifunction_lock_out_oe_b <= phase_err || pd_act[0];
    end else begin
      multifunction_lock_out      <= lock_detect;
      multifunction_lock_out_oe_b <= 1'b0;
    end
  end
endmodule // pdc_device
`default_nettype wire

// File: pdc_host.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_host import pdc_pkg::*; #(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  pdc_link_if.host         link
);
  // ****************************************************
  // register slave
  // ****************************************************
  pdc_host_state_t   state;
  logic [WORD_W-1:0] last_word;
  logic [WORD_W-1:0] shifter;
  logic [4:0]        bits_left;
  logic [7:0]        div_cnt;
  logic              dropped;
  logic              busy;
  logic              mapped;
  logic              wr_word;
  logic              wr_status;

  assign busy      = (state != PDC_IDLE);
  assign mapped    = (paddr == REG_WORD) || (paddr == REG_STATUS);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;
  assign wr_word   = psel && penable && pwrite && (paddr == REG_WORD);
  assign wr_status = psel && penable && pwrite && (paddr == REG_STATUS);

  // read data prepared in the setup cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        REG_WORD:   prdata <= {8'h00, last_word};
        REG_STATUS: prdata <= {30'h0000_0000, dropped, busy};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  // a word written while busy is lost; set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dropped <= 1'b0;
    end else if (wr_word && busy) begin
      dropped <= 1'b1;
    end else if (wr_status && pwdata[ST_DROPPED]) begin
      dropped <= 1'b0;
    end
  end

  // ****************************************************
  // serial link, clock made by divider
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state      <= PDC_IDLE;
      last_word  <= WORD_RST;
      shifter    <= WORD_RST;
      bits_left  <= 5'h00;
      div_cnt    <= 8'h00;
      link.sdata <= 1'b0;
      link.sclk  <= 1'b0;
      link.le    <= 1'b0;
    end else begin
      case (state)
        PDC_IDLE: begin
          if (wr_word) begin
            last_word  <= pwdata[WORD_W-1:0];
            shifter    <= pwdata[WORD_W-1:0];
            bits_left  <= 5'(WORD_W);
            div_cnt    <= 8'h00;
            link.sdata <= pwdata[WORD_W-1];
            state      <= PDC_CLK_LO;
          end
        end
        PDC_CLK_LO: begin
          if (div_cnt == 8'(HALF_CYC - 1)) begin
            div_cnt   <= 8'h00;
            link.sclk <= 1'b1;
            state     <= PDC_CLK_HI;
          end else begin
            div_cnt <= div_cnt + 8'h01;
          end
        end
        PDC_CLK_HI: begin
          if (div_cnt == 8'(HALF_CYC - 1)) begin
            div_cnt    <= 8'h00;
            link.sclk  <= 1'b0;
            shifter    <= {shifter[WORD_W-2:0], 1'b0};
            link.sdata <= shifter[WORD_W-2];
            bits_left  <= bits_left - 5'h01;
            if (bits_left == 5'h01) begin
              link.le <= 1'b1;
              state   <= PDC_LATCH;
            end else begin
              state <= PDC_CLK_LO;
            end
          end else begin
            div_cnt <= div_cnt + 8'h01;
          end
        end
        PDC_LATCH: begin
          if (div_cnt == 8'(HALF_CYC - 1)) begin
            div_cnt <= 8'h00;
            link.le <= 1'b0;
            state   <= PDC_IDLE;
          end else begin
            div_cnt <= div_cnt + 8'h01;
          end
        end
        default: state <= PDC_IDLE;
      endcase
    end
  end
endmodule // pdc_host
`default_nettype wire

// File: pdc_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_link_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sdata,
  input wire logic le,
  input wire logic sclk,
  input wire logic ref_tick,
  input wire logic lock_detect,
  input wire logic rf_loop_powerdown
);
  // ****************************************************
  // helper: serial clock rises since the last latch
  // ****************************************************
  logic [5:0] bit_cnt;
  logic       sclk_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b || le) begin
      bit_cnt <= 6'h00;
    end else if (sclk && !sclk_q) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end
  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_latch_clk_low: assert property (le |-> !sclk)
    else $error("serial clock high during latch pulse");
  a_latch_width: assert property ($rose(le) |-> le[*2] ##1 !le)
    else $error("latch pulse width wrong");
  a_sclk_high_len: assert property ($rose(sclk) |-> sclk[*2] ##1 !sclk)
    else $error("serial clock high phase wrong");
  a_sclk_low_len: assert property ($fell(sclk) |-> !sclk[*2])
    else $error("serial clock low phase too short");
  a_data_hold: assert property (sclk |-> $stable(sdata))
    else $error("serial data moved while clock high");
  a_word_bits: assert property ($rose(le) |-> bit_cnt == 6'h18)
    else $error("latch not preceded by 24 bits");
  a_pd_lock_low: assert property (
    rf_loop_powerdown && $past(rf_loop_powerdown) |-> !lock_detect)
    else $error("lock high during power-down");
  a_lock_on_tick: assert property ($rose(lock_detect) |-> $past(ref_tick))
    else $error("lock rose away from a reference tick");
  a_lock_drop_why: assert property (
    $fell(lock_detect) |-> $past(ref_tick) || rf_loop_powerdown)
    else $error("lock fell without tick or power-down");
endmodule // pdc_link_monitor
`default_nettype wire

// File: dual_pll_divider_power_lock_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_pll_divider_power_lock_ctrl_tb import pdc_pkg::*;;
  logic        clk              = 1'b0;
  logic        rst_b            = 1'b0;
  logic        psel             = 1'b0;
  logic        penable          = 1'b0;
  logic        pwrite           = 1'b0;
  logic [7:0]  paddr            = 8'h00;
  logic [31:0] pwdata           = 32'h0000_0000;
  logic        ref_tick         = 1'b0;
  logic        phase_err        = 1'b0;
  logic        rf_cp_pulse_done = 1'b0;
  logic        if_cp_pulse_done = 1'b0;
  logic        frac_mod16       = 1'b0;
  logic        analog_ld        = 1'b0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, perr;
  logic [4:0]  swal, fmod;
  logic [9:0]  prog;
  logic [3:0]  frac;
  logic [5:0]  pmod;
  logic [15:0] nval;
  logic        finv, sor, rf_pd, gp0, oe0, gp1, oe1, lock, mlo, mlo_oe;
  logic        prs, if_pd;
  logic [23:0] last_w           = 24'h00_0000;
  logic [23:0] sh               = 24'h00_0000;
  logic        sclk_q           = 1'b0;
  logic        le_q             = 1'b0;
  int          failures         = 0;
  int          cmp_count        = 0;
  pdc_link_if lnk ();
  pdc_host #(.HALF_CYC(2)) i_pdc_host (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk.host));
  pdc_device #(.LARGE_VARIANT(1'b1)) i_pdc_device (.clk(clk),
    .rst_b(rst_b), .link(lnk.dev), .frac_mod16(frac_mod16),
    .analog_ld_select(analog_ld), .ref_tick(ref_tick),
    .phase_err(phase_err), .rf_cp_pulse_done(rf_cp_pulse_done),
    .if_cp_pulse_done(if_cp_pulse_done), .rf_swallow_count(swal),
    .rf_program_count(prog), .fraction_numerator(frac),
    .fraction_modulus(fmod), .frac_code_invalid(finv),
    .swallow_out_of_range(sor), .prescaler_ratio_select(prs),
    .prescaler_modulus(pmod), .rf_n_value(nval), .rf_counter_reset(),
    .if_counter_reset(), .rf_loop_powerdown(rf_pd),
    .if_loop_powerdown(if_pd), .gp_output_pin0(gp0),
    .gp_output_pin0_oe_b(oe0), .gp_output_pin1(gp1),
    .gp_output_pin1_oe_b(oe1), .lock_detect(lock),
    .multifunction_lock_out(mlo), .multifunction_lock_out_oe_b(mlo_oe));
  pdc_link_monitor i_pdc_link_monitor (.clk(clk), .rst_b(rst_b),
    .sdata(lnk.sdata), .le(lnk.le), .sclk(lnk.sclk), .ref_tick(ref_tick),
    .lock_detect(lock), .rf_loop_powerdown(rf_pd));
  always #4 clk = ~clk;
  // ****************************************************
  // tasks
  // ****************************************************
  task automatic stop_test();
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // optional second write lands while busy and must be dropped
  task automatic send(input logic [23:0] w, input bit dbl);
    last_w = w;
    apb(1'b1, REG_WORD, {8'h00, w});
    if (dbl) begin
      apb(1'b1, REG_WORD, 32'h00ff_ffff);
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      chk(q[ST_DROPPED], 1'b1);
      apb(1'b1, REG_STATUS, 32'h0000_0002);
    end
    do apb(1'b0, REG_STATUS, 32'h0000_0000);
    while (q[ST_BUSY] !== 1'b0);
    chk(q[1:0], 2'b00);
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [23:0] rfw(logic pd, logic ps, logic [9:0] b,
                                      logic [4:0] a, logic [3:0] f);
    return {1'b0, pd, ps, b, a, f, SEL_RF_N};
  endfunction
  function automatic logic [23:0] ifw(logic md, logic ac, logic o1,
                                      logic o0);
    return {2'b00, md, ac, 1'b0, o1, o0, 12'h007, 3'h0, SEL_IF_N};
  endfunction
  task automatic rfcase(input logic ps, input logic [9:0] b,
                        input logic [4:0] a, input logic [3:0] f,
                        input logic m16, input bit dbl);
    logic [5:0] p;
    p = ps ? P_BIG_HI : P_BIG_LO;
    @(posedge clk);
    frac_mod16 <= m16;
    send(rfw(1'b0, ps, b, a, f), dbl);
    chk(swal, a);
    chk(sor, 1'b0);
    chk(prog, b);
    chk(frac, f);
    chk(fmod, m16 ? MOD_16 : MOD_15);
    chk(finv, !m16 && f == 4'hf);
    chk(pmod, p);
    chk(prs, ps);
    chk(nval, 32'(p) * 32'(b) + 32'(a));
  endtask
  // one reference cycle of nine clocks, error high for e of them
  task automatic refc(input int e);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      phase_err <= (i < e);
      ref_tick <= (i == 7);
    end
    @(posedge clk);
    ref_tick <= 1'b0;
    @(negedge clk);
  endtask
  // ****************************************************
  // wire watch: bits arrive msb first
  // ****************************************************
  always @(negedge clk) begin
    sclk_q <= lnk.sclk;
    le_q <= lnk.le;
    if (lnk.sclk && !sclk_q) sh <= {sh[22:0], lnk.sdata};
    if (lnk.le && !le_q) chk(sh, last_w);
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    stop_test();
  end
  // ****************************************************
  // sequence
  // ****************************************************
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(perr, 1'b1);
    chk(q, 32'h0000_0000);
    rfcase(1'b1, 10'h3ff, 5'h1f, 4'hf, 1'b1, 1'b1);
    apb(1'b0, REG_WORD, 32'h0000_0000);
    chk(q, {8'h00, last_w});
    rfcase(1'b0, 10'h003, 5'h01, 4'hf, 1'b0, 1'b0);
    rfcase(1'b0, 10'h021, 5'h0a, 4'h7, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      send(ifw(1'b0, 1'b0, k[1], k[0]), 1'b0);
      chk({gp1, gp0, oe1, oe0}, {k[1], k[0], 2'b00});
    end
    send(ifw(1'b0, 1'b1, 1'b1, 1'b1), 1'b0);
    send({2'b00, 1'b1, 19'h0_0000, SEL_RF_R}, 1'b0);
    chk({gp0, oe0, oe1}, 3'b001);
    send({2'b00, 1'b1, 19'h0_0000, SEL_IF_R}, 1'b0);
    chk({gp1, oe1}, 2'b00);
    send({2'b00, 1'b0, 19'h0_0000, SEL_RF_R}, 1'b0);
    chk({oe0, gp1, oe1}, 3'b100);
    repeat (4) refc(1);
    refc(2);
    repeat (4) refc(1);
    chk(lock, 1'b0);
    refc(1);
    chk(lock, 1'b1);
    @(negedge clk);
    chk({mlo, mlo_oe}, 2'b10);
    refc(3);
    chk(lock, 1'b1);
    refc(4);
    chk(lock, 1'b0);
    repeat (5) refc(0);
    chk(lock, 1'b1);
    @(posedge clk);
    analog_ld <= 1'b1;
    repeat (3) @(negedge clk);
    chk({mlo, mlo_oe}, 2'b00);
    send(ifw(1'b0, 1'b0, 1'b0, 1'b0), 1'b0);
    send(rfw(1'b1, 1'b0, 10'h00a, 5'h03, 4'h0), 1'b0);
    chk({rf_pd, lock, mlo_oe}, 3'b101);
    send(rfw(1'b1, 1'b0, 10'h00a, 5'h05, 4'h0), 1'b0);
    chk(swal, 5'h05);
    send(rfw(1'b0, 1'b0, 10'h00a, 5'h05, 4'h0), 1'b0);
    chk(rf_pd, 1'b0);
    send(ifw(1'b1, 1'b0, 1'b0, 1'b0), 1'b0);
    send(rfw(1'b1, 1'b0, 10'h00a, 5'h05, 4'h0), 1'b0);
    chk(rf_pd, 1'b0);
    @(posedge clk);
    rf_cp_pulse_done <= 1'b1;
    @(posedge clk);
    rf_cp_pulse_done <= 1'b0;
    repeat (3) @(negedge clk);
    chk(rf_pd, 1'b1);
    send(ifw(1'b1, 1'b0, 1'b0, 1'b0) | 24'h40_0000, 1'b0);
    chk(if_pd, 1'b0);
    @(posedge clk);
    if_cp_pulse_done <= 1'b1;
    @(posedge clk);
    if_cp_pulse_done <= 1'b0;
    repeat (3) @(negedge clk);
    chk(if_pd, 1'b1);
    stop_test();
  end
endmodule // dual_pll_divider_power_lock_ctrl_tb
`default_nettype wire
